/* bench/pfc_flash_model.sv */
// Behavioural model of the flash device on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h0011, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0022, // Arbitrary value
   parameter logic [15:0] BYPASS_CMD = 16'h0020, // Bypass entry data
   parameter int BUSY_CYC = 60, // Embedded algorithm length
   parameter int READY_CYC = 20 // Internal reset time when busy
) (
   input wire logic clk_sys, // Model time base
   input wire logic ce_n, // Chip enable
   input wire logic oe_n, // Output enable
   input wire logic we_n, // Write strobe
   input wire logic reset_n, // Hardware reset
   input wire logic [17:0] addr, // Address
   input wire logic [15:0] dq_in, // Data from host
   output logic [15:0] dq_out, // Data to host
   output logic ready_busy_out // Low while busy
);
   logic [15:0] mem [4096]; // Sector is address bits 17:15 here
   logic [15:0] rd_val, last_q, lat_d, pd;
   logic [17:0] lat_a, pa;
   logic we_q, rst_q, id_mode, bypass, drive;
   int cyc, busy_cnt, kind;
   // Device drives only when selected, enabled and out of reset
   assign drive = !ce_n && !oe_n && reset_n;
   assign dq_out = drive ? rd_val : ~last_q;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {we_q, rst_q, id_mode, bypass} = 4'hC;
      {cyc, busy_cnt, kind} = 96'h0;
      {rd_val, last_q} = 32'h0;
      ready_busy_out = 1'b1;
   end
   function automatic int idx(input logic [17:0] a);
      return {a[17:15], a[8:0]};
   endfunction
   // Command interpreter, one call per completed write cycle while not busy
   task automatic take(input logic [17:0] a, input logic [15:0] d);
      logic u1, u2;
      u1 = (a[10:0] == pfc_pkg::UNLOCK_A1);
      u2 = (a[10:0] == pfc_pkg::UNLOCK_A2);
      if (cyc != 3 && d == pfc_pkg::CMD_READ_RESET) begin
         cyc = 0;
         id_mode = 1'b0;
      end else case (cyc)
         0: cyc = (bypass && d == pfc_pkg::CMD_PROGRAM) ? 3 :
               (u1 && d == pfc_pkg::CMD_UNLOCK1) ? 1 : 0;
         1, 5: cyc = (u2 && d == pfc_pkg::CMD_UNLOCK2) ? cyc + 1 : 0;
         2: begin
            cyc = 0;
            if (u1 && d == pfc_pkg::CMD_IDENT) id_mode = 1'b1;
            if (u1 && d == pfc_pkg::CMD_PROGRAM) cyc = 3;
            if (u1 && d == pfc_pkg::CMD_ERASE_SETUP) cyc = 4;
            if (u1 && d == BYPASS_CMD) bypass = 1'b1;
         end
         4: cyc = (u1 && d == pfc_pkg::CMD_UNLOCK1) ? 5 : 0;
         default: begin
            kind = (cyc == 3) ? 1 : (u1 && d == pfc_pkg::CMD_CHIP_ERASE) ? 2 :
               (d == pfc_pkg::CMD_SECTOR_ERASE) ? 3 : 0;
            {pa, pd} = {a, d};
            busy_cnt = (kind != 0) ? BUSY_CYC : 0;
            cyc = 0;
         end
      endcase
   endtask
   // Commits the result of a finished embedded algorithm
   task automatic finish_op();
      for (int i = 0; i < 4096; i++) begin
         if (kind == 2 || (kind == 3 && i[11:9] == pa[17:15])) mem[i] = 16'hFFFF;
      end
      if (kind == 1) mem[idx(pa)] = mem[idx(pa)] & pd;
      kind = 0;
   endtask
   // Bus sampling, reset handling and algorithm timing
   always @(posedge clk_sys) begin
      if (drive) last_q <= rd_val;
      rd_val <= id_mode ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[idx(addr)];
      if (!reset_n) begin
         if (rst_q && busy_cnt > 0) busy_cnt = READY_CYC;
         {cyc, kind, id_mode, bypass} = 66'h0;
      end else begin
         if (!we_n && !ce_n) {lat_a, lat_d} = {addr, dq_in};
         if (we_n && !we_q && busy_cnt == 0) take(lat_a, lat_d);
      end
      if (busy_cnt > 0) begin
         busy_cnt--;
         if (busy_cnt == 0) finish_op();
      end
      {we_q, rst_q} = {we_n, reset_n};
      ready_busy_out <= (busy_cnt == 0);
   end
endmodule
`default_nettype wire

/* bench/pfc_host_properties.sv */
// Pin-level assertion checker for the parallel flash host controller
`timescale 1ns/1ps
`default_nettype none
module pfc_host_properties #(
   parameter int ADDR_W = pfc_pkg::ADDR_W,
   parameter int DATA_W = pfc_pkg::DATA_W
) (
   input wire logic clk_sys, // Clock
   input wire logic sys_rst, // Reset
   input wire logic req_valid, // Request
   input wire pfc_pkg::pfc_op_e req_op, // Operation
   input wire logic [ADDR_W-1:0] req_addr, // Address
   input wire logic [DATA_W-1:0] req_data, // Data
   input wire logic req_ready, // Idle
   input wire logic rsp_valid, // Answer pulse
   input wire logic [DATA_W-1:0] rsp_data, // Answer
   input wire logic busy_seen, // Busy flag
   input wire logic flash_ce_n, // Chip enable
   input wire logic flash_oe_n, // Output enable
   input wire logic flash_we_n, // Write strobe
   input wire logic flash_reset_n, // Flash reset
   input wire logic [ADDR_W-1:0] flash_addr, // Address pins
   input wire logic [DATA_W-1:0] flash_dq_o, // Data out
   input wire logic flash_dq_oe, // Data drive
   input wire logic [DATA_W-1:0] flash_dq_i, // Data in
   input wire logic ready_busy_out // Device busy, low
);
   int lo_cnt;
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Length of the current flash reset pulse
   always_ff @(posedge clk_sys) begin
      lo_cnt <= flash_reset_n ? 0 : lo_cnt + 1;
   end
   // Strobe combinations and the first unlock address on the flash pins
   chk_read_strobes:
      assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
      else $error("Output enable low outside a clean read");
   chk_write_strobes:
      assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("Write strobe low outside a clean write");
   chk_bus_released:
      assert property (!flash_oe_n |-> !flash_dq_oe)
      else $error("Host drives data while the device may");
   chk_unlock_addr:
      assert property (!flash_we_n && flash_dq_o == pfc_pkg::CMD_UNLOCK1
         |-> flash_addr[10:0] == pfc_pkg::UNLOCK_A1)
      else $error("First unlock data at the wrong address");
   // Reset pulse width and the pause before the next read
   chk_reset_pulse:
      assert property ($rose(flash_reset_n) |-> lo_cnt >= pfc_pkg::RESET_PULSE_CYC)
      else $error("Flash reset pulse too short");
   chk_reset_to_read:
      assert property ($rose(flash_reset_n) |-> flash_oe_n [*8])
      else $error("Read started too soon after flash reset");
   // Read answer timing
   chk_read_latency:
      assert property (req_valid && req_ready && req_op == pfc_pkg::PFC_OP_READ
         |=> !rsp_valid [*8] ##[11:13] rsp_valid)
      else $error("Read answer outside its window");
   chk_rsp_pulse:
      assert property (rsp_valid |=> !rsp_valid)
      else $error("Answer pulse longer than one cycle");
   cov_read: cover property (rsp_valid);
   cov_write: cover property ($rose(flash_we_n));
   cov_reset: cover property ($rose(flash_reset_n));
endmodule
bind pfc_host pfc_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
   i_pfc_host_properties (.*);
`default_nettype wire

/* bench/test_pfc_host.sv */
// Self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
`default_nettype none
module test_pfc_host;
   localparam logic [15:0] MFR = 16'h0011; // Arbitrary value
   localparam logic [15:0] DEV = 16'h0022; // Arbitrary value
   typedef struct packed {
      pfc_pkg::pfc_op_e op;
      logic [17:0] a;
      logic [15:0] d;
      logic chk;
      logic [15:0] e;
   } pfc_row_s;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   pfc_pkg::pfc_op_e req_op = pfc_pkg::PFC_OP_READ;
   logic [17:0] req_addr = 18'h00000;
   logic [15:0] req_data = 16'h0000;
   logic req_ready, rsp_valid, busy_seen, ce_n, oe_n, we_n, rst_n, dq_oe, rb;
   logic [15:0] rsp_data, dq_o, dq_dev, dq_i, v;
   logic [17:0] fa;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   pfc_row_s rows [12] = '{
      '{pfc_pkg::PFC_OP_READ, 18'h00100, 16'h0000, 1'b1, 16'hFFFF},
      '{pfc_pkg::PFC_OP_PROGRAM, 18'h00100, 16'h1234, 1'b0, 16'h0000},
      '{pfc_pkg::PFC_OP_READ, 18'h00100, 16'h0000, 1'b1, 16'h1234},
      '{pfc_pkg::PFC_OP_PROGRAM, 18'h08100, 16'h5A5A, 1'b0, 16'h0000},
      '{pfc_pkg::PFC_OP_ID_READ, 18'h00000, 16'h0000, 1'b1, {8'h00, MFR[7:0]}},
      '{pfc_pkg::PFC_OP_ID_READ, 18'h00001, 16'h0000, 1'b1, {8'h00, DEV[7:0]}},
      '{pfc_pkg::PFC_OP_READ, 18'h08100, 16'h0000, 1'b1, 16'h5A5A},
      '{pfc_pkg::PFC_OP_SECTOR_ERASE, 18'h08000, 16'h0000, 1'b0, 16'h0000},
      '{pfc_pkg::PFC_OP_READ, 18'h08100, 16'h0000, 1'b1, 16'hFFFF},
      '{pfc_pkg::PFC_OP_READ_RESET, 18'h3FFFF, 16'h0000, 1'b0, 16'h0000},
      '{pfc_pkg::PFC_OP_READ, 18'h00100, 16'h0000, 1'b1, 16'h1234},
      '{pfc_pkg::PFC_OP_CHIP_ERASE, 18'h00000, 16'h0000, 1'b0, 16'h0000}};
   // Split data pin: host drive wins, otherwise the device side
   assign dq_i = dq_oe ? dq_o : dq_dev;
   always #2.5 clk_sys = ~clk_sys;
   pfc_host i_pfc_host (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .busy_seen(busy_seen), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n),
      .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe),
      .flash_dq_i(dq_i), .ready_busy_out(rb));
   // Model enters fast mode on the standard program setup, as the host assumes
   pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV),
      .BYPASS_CMD(pfc_pkg::CMD_PROGRAM)) i_pfc_flash_model (
      .clk_sys(clk_sys), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .reset_n(rst_n), .addr(fa), .dq_in(dq_o), .dq_out(dq_dev),
      .ready_busy_out(rb));
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for idle (and a quiet device if asked), then requests once
   task automatic issue(input pfc_pkg::pfc_op_e op, input logic [17:0] a,
      input logic [15:0] d, input logic bw);
      @(negedge clk_sys);
      while (req_ready !== 1'b1 || (bw && busy_seen !== 1'b0)) begin
         @(negedge clk_sys);
      end
      @(posedge clk_sys);
      req_valid <= 1'b1;
      {req_op, req_addr, req_data} <= {op, a, d};
      @(posedge clk_sys);
      req_valid <= 1'b0;
   endtask
   // Waits for the answer pulse of the request just taken
   task automatic wait_rsp(output logic [15:0] r);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      r = rsp_data;
   endtask
   task automatic read_word(input logic [17:0] a, output logic [15:0] r);
      issue(pfc_pkg::PFC_OP_READ, a, 16'h0000, 1'b1);
      wait_rsp(r);
   endtask
   // Cuts a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end
   // Reset, table of ordinary cases, then the awkward ones
   initial begin
      repeat (20) @(posedge clk_sys);
      chk16({15'h0, rst_n, ce_n}, 16'h0001);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].a, rows[i].d, 1'b1);
         if (rows[i].chk) begin
            wait_rsp(v);
            chk16(v, rows[i].e);
         end
      end
      read_word(18'h00100, v);
      chk16(v, 16'hFFFF);
      issue(pfc_pkg::PFC_OP_PROGRAM, 18'h00200, 16'h0F0F, 1'b1);
      issue(pfc_pkg::PFC_OP_HW_RESET, 18'h00000, 16'h0000, 1'b0);
      chk16({15'h0, busy_seen}, 16'h0001);
      read_word(18'h00200, v);
      chk16(v, 16'hFFFF);
      issue(pfc_pkg::PFC_OP_PROGRAM, 18'h00200, 16'h0F0F, 1'b1);
      read_word(18'h00200, v);
      chk16(v, 16'h0F0F);
      issue(pfc_pkg::PFC_OP_FAST_PROG, 18'h00300, 16'h3C3C, 1'b1);
      issue(pfc_pkg::PFC_OP_FAST_PROG, 18'h00301, 16'h4B4B, 1'b1);
      read_word(18'h00301, v);
      chk16(v, 16'h4B4B);
      complete_run();
   end
endmodule
`default_nettype wire

/* hdl/pfc_host.sv */
// Host controller driving an asynchronous parallel flash over its pins
`timescale 1ns/1ps
`default_nettype none
module pfc_host #(
   parameter int ADDR_W = pfc_pkg::ADDR_W,
   parameter int DATA_W = pfc_pkg::DATA_W
) (
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic req_valid, // Operation request
   input wire pfc_pkg::pfc_op_e req_op, // Operation kind
   input wire logic [ADDR_W-1:0] req_addr, // Address or sector address
   input wire logic [DATA_W-1:0] req_data, // Program data
   output logic req_ready, // Idle and accepting a request
   output logic rsp_valid, // One-cycle read answer pulse
   output logic [DATA_W-1:0] rsp_data, // Read data
   output logic busy_seen, // Flash ready/busy low, synchronised
   output logic flash_ce_n, // Chip enable, active low
   output logic flash_oe_n, // Output enable, active low
   output logic flash_we_n, // Write strobe, active low
   output logic flash_reset_n, // Hardware reset, active low
   output logic [ADDR_W-1:0] flash_addr, // Address pins
   output logic [DATA_W-1:0] flash_dq_o, // Data out
   output logic flash_dq_oe, // Data output enable, high drives
   input wire logic [DATA_W-1:0] flash_dq_i, // Data in from pins
   input wire logic ready_busy_out // Flash ready/busy, low is busy
);
   typedef struct packed {
      pfc_pkg::pfc_state_e st;
      pfc_pkg::pfc_pins_s pins;
      logic [pfc_pkg::CNT_W-1:0] cnt;
      logic [2:0] step;
      logic [2:0] nsteps;
      pfc_pkg::pfc_op_e op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic bypass;
      logic ready;
      logic rsp_v;
      logic [DATA_W-1:0] rsp_d;
      logic [1:0] rb_sync;
   } pfc_state_s;

   pfc_state_s s_reg, s_next;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;

   // Address and data of the current command cycle
   always_comb begin
      cyc_addr = ADDR_W'(pfc_pkg::UNLOCK_A1);
      cyc_data = pfc_pkg::CMD_UNLOCK1;
      if (s_reg.bypass && s_reg.op == pfc_pkg::PFC_OP_FAST_PROG) begin
         cyc_addr = (s_reg.step == 3'd0) ? '0 : s_reg.addr;
         cyc_data = (s_reg.step == 3'd0) ? pfc_pkg::CMD_PROGRAM : s_reg.data;
      end else begin
         case (s_reg.step)
            3'd0: begin
               cyc_addr = ADDR_W'(pfc_pkg::UNLOCK_A1);
               cyc_data = (s_reg.op == pfc_pkg::PFC_OP_READ_RESET) ?
                  pfc_pkg::CMD_READ_RESET : pfc_pkg::CMD_UNLOCK1;
            end
            3'd1, 3'd4: begin
               cyc_addr = ADDR_W'(pfc_pkg::UNLOCK_A2);
               cyc_data = pfc_pkg::CMD_UNLOCK2;
            end
            3'd2: begin
               case (s_reg.op)
                  pfc_pkg::PFC_OP_ID_READ: cyc_data = pfc_pkg::CMD_IDENT;
                  pfc_pkg::PFC_OP_CHIP_ERASE,
                  pfc_pkg::PFC_OP_SECTOR_ERASE:
                     cyc_data = pfc_pkg::CMD_ERASE_SETUP;
                  default: cyc_data = pfc_pkg::CMD_PROGRAM;
               endcase
            end
            3'd3: begin
               if (s_reg.op == pfc_pkg::PFC_OP_PROGRAM ||
                   s_reg.op == pfc_pkg::PFC_OP_FAST_PROG) begin
                  cyc_addr = s_reg.addr;
                  cyc_data = s_reg.data;
               end else begin
                  cyc_data = pfc_pkg::CMD_UNLOCK1;
               end
            end
            default: begin
               if (s_reg.op == pfc_pkg::PFC_OP_SECTOR_ERASE) begin
                  cyc_addr = s_reg.addr;
                  cyc_data = pfc_pkg::CMD_SECTOR_ERASE;
               end else begin
                  cyc_data = pfc_pkg::CMD_CHIP_ERASE;
               end
            end
         endcase
      end
   end

   // Next-state logic of the whole controller
   always_comb begin
      s_next = s_reg;
      s_next.rsp_v = 1'b0;
      s_next.rb_sync = {s_reg.rb_sync[0], ready_busy_out};
      case (s_reg.st)
         pfc_pkg::ST_RESET: begin
            // Hold the flash in reset for the minimum pulse
            s_next.pins = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
               addr: '0, dq_out: '0, dq_oe: 1'b0};
            s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::RESET_PULSE_CYC);
            s_next.st = pfc_pkg::ST_RST_PULSE;
            s_next.ready = 1'b0;
         end
         pfc_pkg::ST_RST_PULSE: begin
            if (s_reg.cnt == '0) begin
               s_next.pins.reset_n = 1'b1;
               s_next.bypass = 1'b0;
               s_next.st = pfc_pkg::ST_RST_BUSY;
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         pfc_pkg::ST_RST_BUSY: begin
            // Wait for ready/busy to rise after an aborted algorithm
            if (s_reg.rb_sync[1]) begin
               s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::RESET_TO_READ_CYC);
               s_next.st = pfc_pkg::ST_RST_REC;
            end
         end
         pfc_pkg::ST_RST_REC: begin
            // Reset-to-read delay before the first access
            if (s_reg.cnt == '0) begin
               s_next.st = pfc_pkg::ST_IDLE;
               s_next.ready = 1'b1;
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         pfc_pkg::ST_IDLE: begin
            if (req_valid) begin
               s_next.ready = 1'b0;
               s_next.op = req_op;
               s_next.addr = req_addr;
               s_next.data = req_data;
               s_next.step = '0;
               s_next.pins.ce_n = 1'b0;
               case (req_op)
                  pfc_pkg::PFC_OP_HW_RESET: begin
                     // Interrupted job is dropped, the requester restarts it
                     s_next.pins.ce_n = 1'b1;
                     s_next.st = pfc_pkg::ST_RESET;
                  end
                  pfc_pkg::PFC_OP_READ, pfc_pkg::PFC_OP_ID_READ: begin
                     if (req_op == pfc_pkg::PFC_OP_ID_READ) begin
                        s_next.nsteps = 3'd3;
                        s_next.st = pfc_pkg::ST_WR_HIGH;
                        s_next.cnt = '0;
                     end else begin
                        s_next.pins.addr = req_addr;
                        s_next.pins.oe_n = 1'b0;
                        s_next.pins.dq_oe = 1'b0;
                        s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::ACCESS_CYC);
                        s_next.st = pfc_pkg::ST_RD;
                     end
                  end
                  default: begin
                     case (req_op)
                        pfc_pkg::PFC_OP_READ_RESET: s_next.nsteps = 3'd1;
                        pfc_pkg::PFC_OP_PROGRAM: s_next.nsteps = 3'd4;
                        pfc_pkg::PFC_OP_FAST_PROG:
                           s_next.nsteps = s_reg.bypass ? 3'd2 : 3'd4;
                        default: s_next.nsteps = 3'd6;
                     endcase
                     s_next.cnt = '0;
                     s_next.st = pfc_pkg::ST_WR_HIGH;
                  end
               endcase
            end
         end
         pfc_pkg::ST_WR_HIGH: begin
            // Strobe high time, then start the next write
            if (s_reg.cnt != '0) begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end else if (s_reg.step == s_reg.nsteps) begin
               if (s_reg.op == pfc_pkg::PFC_OP_FAST_PROG) begin
                  s_next.bypass = 1'b1;
               end
               if (s_reg.op == pfc_pkg::PFC_OP_READ_RESET) begin
                  s_next.bypass = 1'b0;
               end
               if (s_reg.op == pfc_pkg::PFC_OP_ID_READ) begin
                  // Identification read of ID address
                  s_next.pins.addr = s_reg.addr[0] ?
                     pfc_pkg::ID_DEV_ADDR : pfc_pkg::ID_MFR_ADDR;
                  s_next.pins.oe_n = 1'b0;
                  s_next.pins.dq_oe = 1'b0; // Release in the same cycle as output enable
                  s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::ACCESS_CYC);
                  s_next.st = pfc_pkg::ST_RD;
               end else begin
                  s_next.pins.ce_n = 1'b1;
                  s_next.st = pfc_pkg::ST_IDLE;
                  s_next.ready = 1'b1;
               end
            end else begin
               s_next.pins.oe_n = 1'b1;
               s_next.pins.we_n = 1'b0;
               s_next.pins.addr = cyc_addr;
               s_next.pins.dq_out = cyc_data;
               s_next.pins.dq_oe = 1'b1;
               s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::WR_PULSE_CYC);
               s_next.st = pfc_pkg::ST_WR_LOW;
            end
         end
         pfc_pkg::ST_WR_LOW: begin
            if (s_reg.cnt == '0) begin
               s_next.pins.we_n = 1'b1;
               s_next.step = s_reg.step + 3'd1;
               s_next.cnt = pfc_pkg::CNT_W'(pfc_pkg::WR_HIGH_CYC);
               s_next.st = pfc_pkg::ST_WR_HIGH;
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         pfc_pkg::ST_RD: begin
            // Data bus released during reads
            s_next.pins.dq_oe = 1'b0;
            if (s_reg.cnt == '0) begin
               s_next.rsp_v = 1'b1;
               s_next.rsp_d = (s_reg.op == pfc_pkg::PFC_OP_ID_READ) ?
                  {{(DATA_W-8){1'b0}}, flash_dq_i[7:0]} : flash_dq_i;
               s_next.pins.oe_n = 1'b1;
               s_next.pins.ce_n = 1'b1;
               s_next.st = pfc_pkg::ST_IDLE;
               s_next.ready = 1'b1;
               if (s_reg.op == pfc_pkg::PFC_OP_ID_READ) begin
                  // Leave identification mode
                  s_next.op = pfc_pkg::PFC_OP_READ_RESET;
                  s_next.step = '0;
                  s_next.nsteps = 3'd1;
                  s_next.pins.ce_n = 1'b0;
                  s_next.cnt = '0;
                  s_next.ready = 1'b0;
                  s_next.st = pfc_pkg::ST_WR_HIGH;
               end
            end else begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end
         end
         default: s_next.st = pfc_pkg::ST_RESET;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_reg <= '{st: pfc_pkg::ST_RESET,
            pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
               addr: '0, dq_out: '0, dq_oe: 1'b0},
            cnt: '0, step: '0, nsteps: '0, op: pfc_pkg::PFC_OP_READ,
            addr: '0, data: '0, bypass: 1'b0, ready: 1'b0, rsp_v: 1'b0,
            rsp_d: '0, rb_sync: 2'b11};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign req_ready = s_reg.ready;
   assign rsp_valid = s_reg.rsp_v;
   assign rsp_data = s_reg.rsp_d;
   assign busy_seen = ~s_reg.rb_sync[1];
   assign flash_ce_n = s_reg.pins.ce_n;
   assign flash_oe_n = s_reg.pins.oe_n;
   assign flash_we_n = s_reg.pins.we_n;
   assign flash_reset_n = s_reg.pins.reset_n;
   assign flash_addr = s_reg.pins.addr;
   assign flash_dq_o = s_reg.pins.dq_out;
   assign flash_dq_oe = s_reg.pins.dq_oe;
endmodule
`default_nettype wire

/* hdl/pfc_pkg.sv */
// Package for the parallel flash host-side bus controller
package pfc_pkg;
   // Widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   // Unlock addresses and command data, word mode
   localparam logic [10:0] UNLOCK_A1 = 11'h555;
   localparam logic [10:0] UNLOCK_A2 = 11'h2AA;
   localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
   localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [15:0] CMD_IDENT = 16'h0090;
   localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
   localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] CMD_READ_RESET = 16'h00F0;
   // Identification read addresses (A1=0,A0=0 / A1=0,A0=1)
   localparam logic [17:0] ID_MFR_ADDR = 18'h00000;
   localparam logic [17:0] ID_DEV_ADDR = 18'h00001;
   // Bus timing in ns and cycles at 200 MHz
   localparam int CLK_PERIOD_NS = 5;
   localparam int ACCESS_NS = 90;
   localparam int WR_PULSE_NS = 35;
   localparam int WR_HIGH_NS = 30;
   localparam int RESET_PULSE_MIN_NS = 500;
   localparam int RESET_TO_READ_DELAY_NS = 50;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_PULSE_CYC =
      (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WR_HIGH_CYC = (WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_CYC =
      (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_TO_READ_CYC =
      (RESET_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // Host operations
   typedef enum logic [2:0] {
      PFC_OP_READ, PFC_OP_ID_READ, PFC_OP_PROGRAM, PFC_OP_CHIP_ERASE,
      PFC_OP_SECTOR_ERASE, PFC_OP_READ_RESET, PFC_OP_HW_RESET, PFC_OP_FAST_PROG
   } pfc_op_e;
   // Flash pin bundle driven by the host
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } pfc_pins_s;
   // Controller state
   typedef enum {
      ST_RESET, ST_RST_WAIT, ST_IDLE, ST_RD, ST_WR_LOW, ST_WR_HIGH,
      ST_RST_PULSE, ST_RST_BUSY, ST_RST_REC
   } pfc_state_e;
endpackage
